// file: logic/mseu_defs.svh
`ifndef MSEU_DEFS_SVH
`define MSEU_DEFS_SVH

// register map, word offsets on the register port
`define MSEU_REG_CTRL 4'h0
`define MSEU_REG_STATUS 4'h1
`define MSEU_REG_ACC_FIRST 4'h2
`define MSEU_REG_ACC_SECOND 4'h3
`define MSEU_REG_PROG_CNT 4'h4
`define MSEU_REG_RET_PTR 4'h5
`define MSEU_REG_FLAGS 4'h6

// reset values
`define MSEU_RST_WORD 16'h0000
`define MSEU_RST_ADDR 15'h0000
`define MSEU_RST_CODE 4'h0
`define MSEU_RST_LEVEL 2'h0

// instruction fields
`define MSEU_IND_BIT 15
`define MSEU_PAGE_BIT 10
`define MSEU_GROUP_BIT 10
`define MSEU_POP_BIT 6
`define MSEU_SKIP_NZ_BIT 9
`define MSEU_SKIP_ACC_BIT 8
`define MSEU_SHIFT_ACC_BIT 4
`define MSEU_SECOND_BIT 11

// opcodes in bits 14..11
`define MSEU_OP_LOAD_FIRST_ACC 4'h0
`define MSEU_OP_LOAD_SECOND_ACC 4'h1
`define MSEU_OP_COMPARE_FIRST_ACC 4'h2
`define MSEU_OP_COMPARE_SECOND_ACC 4'h3
`define MSEU_OP_ADD_TO_FIRST_ACC 4'h4
`define MSEU_OP_ADD_TO_SECOND_ACC 4'h5
`define MSEU_OP_STORE_FIRST_ACC 4'h6
`define MSEU_OP_STORE_SECOND_ACC 4'h7
`define MSEU_OP_CALL_SUBROUTINE 4'h8
`define MSEU_OP_BRANCH_ALWAYS 4'h9
`define MSEU_OP_INCREMENT_SKIP_ZERO 4'hA
`define MSEU_OP_DECREMENT_SKIP_ZERO 4'hB
`define MSEU_OP_LOGIC_AND 4'hC
`define MSEU_OP_INCLUSIVE_OR_OP 4'hD
`define MSEU_OP_SUBROUTINE_RETURN 4'hE
`define MSEU_OP_SHIFT_SKIP 4'hF

// select-code stack and priority levels
`define MSEU_STACK_DEPTH 3
`define MSEU_LEVEL_LOW 2'h1
`define MSEU_LEVEL_HIGH 2'h2

`endif

// file: logic/mseu_pkg.sv
package mseu_pkg;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_FETCH = 3'b001,
        S_DECODE = 3'b010,
        S_IND_REQ = 3'b011,
        S_IND_DATA = 3'b100,
        S_OPER = 3'b101,
        S_EXEC = 3'b110
    } mseu_state_t;

    typedef enum logic [1:0] {
        SH_ARITH_RIGHT = 2'b00,
        SH_LOGIC_RIGHT = 2'b01,
        SH_LOGIC_LEFT = 2'b10,
        SH_ROTATE_RIGHT = 2'b11
    } mseu_shift_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [14:0] addr;
        logic [15:0] data;
    } mseu_mem_req_t;

    typedef struct packed {
        logic carry;
        logic signedWrapFlag;
    } mseu_flags_t;

endpackage : mseu_pkg

// file: logic/mseu_core.sv
`timescale 1ns/1ps
`include "mseu_defs.svh"
// Operation
// - offset bits 0-9, bit 10 picks page
// - bit 15 set makes reference indirect
// - load fills accumulator, store writes memory
// - compare all bits, skip when unequal
// - add into accumulator, carry sets flag
// - overflow when bit 14 xor 15 carry
// - call bumps pointer, saves location, jumps
// - branch goes to effective address
// - increment word, skip on zero, flags kept
// - decrement word, skip on zero, flags kept
// - and or into first accumulator
// - return to saved plus displacement, pointer down
// - pop option pops codes, lowers priority
// - three-deep four-bit select code stack
// - grant uses level currently in service
// - shift amount field holds n minus one
// - arithmetic right fills with sign bit
// - logical right clears vacated high bits
// - left shift clears low n bits
// - rotate right feeds bit 0 upward
// - skip carries six-bit relative displacement
// - displacement bit 5 is the sign
module mseu_core (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    output mseu_pkg::mseu_mem_req_t memReq,
    input wire logic [15:0] memRdData,
    input wire logic intReqPin,
    input wire logic intHighPin,
    input wire logic [3:0] intCodePin,
    output logic intGrant,
    output logic [3:0] selCode
);

////////////////////////////////////////////////////////////////////////////////
mseu_pkg::mseu_state_t stateReg, stateNext;
mseu_pkg::mseu_mem_req_t memReg, memNext;
mseu_pkg::mseu_flags_t flagsReg, flagsNext;
mseu_pkg::mseu_shift_t shiftKind;
logic runReg;
logic [15:0] irReg, irNext;
logic [14:0] eaReg, eaNext;
logic [14:0] pcReg, pcNext;
logic [14:0] rspReg, rspNext;
logic [15:0] accAReg, accANext;
logic [15:0] accBReg, accBNext;
logic [15:0] curAcc, operand, result;
logic [16:0] sum17;
logic [15:0] low16;
logic [4:0] shiftAmt;
logic [31:0] rotWide;
logic [14:0] formedAddr, disp15;
logic needsOperand, skipCond, popReq;
logic [5:0] syncA, syncB;
logic [1:0] levelReg, reqLevel;
logic [3:0] stackReg [0:`MSEU_STACK_DEPTH-1];
logic grantNow;
logic [15:0] rdMux;

assign memReq = memReg;
assign selCode = stackReg[0];

////////////////////////////////////////////////////////////////////////////////
// operand formation, decoded from the word arriving in S_DECODE
always_comb begin
    formedAddr = {memRdData[`MSEU_PAGE_BIT] ? pcReg[14:10] : 5'h00, memRdData[9:0]};
    needsOperand = 1'b0;
    unique case (memRdData[14:11])
        `MSEU_OP_LOAD_FIRST_ACC, `MSEU_OP_LOAD_SECOND_ACC,
        `MSEU_OP_COMPARE_FIRST_ACC, `MSEU_OP_COMPARE_SECOND_ACC,
        `MSEU_OP_ADD_TO_FIRST_ACC, `MSEU_OP_ADD_TO_SECOND_ACC,
        `MSEU_OP_INCREMENT_SKIP_ZERO, `MSEU_OP_DECREMENT_SKIP_ZERO,
        `MSEU_OP_LOGIC_AND, `MSEU_OP_INCLUSIVE_OR_OP: begin
            needsOperand = 1'b1;
        end
        `MSEU_OP_STORE_FIRST_ACC, `MSEU_OP_STORE_SECOND_ACC,
        `MSEU_OP_CALL_SUBROUTINE, `MSEU_OP_BRANCH_ALWAYS,
        `MSEU_OP_SUBROUTINE_RETURN, `MSEU_OP_SHIFT_SKIP: begin
            needsOperand = 1'b0;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// datapath terms used in S_EXEC
always_comb begin
    operand = memRdData;
    curAcc = irReg[`MSEU_SECOND_BIT] ? accBReg : accAReg;
    sum17 = {1'b0, curAcc} + {1'b0, operand};
    low16 = {1'b0, curAcc[14:0]} + {1'b0, operand[14:0]};
    shiftAmt = {1'b0, irReg[3:0]} + 5'h01;
    shiftKind = mseu_pkg::mseu_shift_t'(irReg[6:5]);
    disp15 = {{9{irReg[5]}}, irReg[5:0]};
    rotWide = {accSel(irReg), accSel(irReg)} >> shiftAmt;
    unique case (shiftKind)
        mseu_pkg::SH_ARITH_RIGHT: result = 16'($signed(accSel(irReg)) >>> shiftAmt);
        mseu_pkg::SH_LOGIC_RIGHT: result = accSel(irReg) >> shiftAmt;
        mseu_pkg::SH_LOGIC_LEFT: result = accSel(irReg) << shiftAmt;
        mseu_pkg::SH_ROTATE_RIGHT: result = rotWide[15:0];
    endcase
    skipCond = ((irReg[`MSEU_SKIP_ACC_BIT] ? accBReg : accAReg) == 16'h0000) ^ irReg[`MSEU_SKIP_NZ_BIT];
end

function automatic logic [15:0] accSel(input logic [15:0] ir);
    accSel = ir[`MSEU_SHIFT_ACC_BIT] ? accBReg : accAReg;
endfunction : accSel

////////////////////////////////////////////////////////////////////////////////
// sequencer: one memory request at a time, data returns the cycle after it
always_comb begin
    stateNext = stateReg;
    irNext = irReg;
    eaNext = eaReg;
    pcNext = pcReg;
    rspNext = rspReg;
    accANext = accAReg;
    accBNext = accBReg;
    flagsNext = flagsReg;
    memNext = memReg;
    memNext.rd = 1'b0;
    memNext.wr = 1'b0;
    popReq = 1'b0;
    unique case (stateReg)
        mseu_pkg::S_IDLE: begin
            // software may only load state while nothing is in flight
            if (regWr) begin
                unique case (regAddr)
                    `MSEU_REG_ACC_FIRST: accANext = regWrData;
                    `MSEU_REG_ACC_SECOND: accBNext = regWrData;
                    `MSEU_REG_PROG_CNT: pcNext = regWrData[14:0];
                    `MSEU_REG_RET_PTR: rspNext = regWrData[14:0];
                    `MSEU_REG_FLAGS: flagsNext = regWrData[1:0];
                    default: begin
                    end
                endcase
            end else if (runReg) begin
                memNext.rd = 1'b1;
                memNext.addr = pcReg;
                stateNext = mseu_pkg::S_FETCH;
            end
        end
        mseu_pkg::S_FETCH: begin
            stateNext = mseu_pkg::S_DECODE;
        end
        mseu_pkg::S_DECODE: begin
            irNext = memRdData;
            eaNext = formedAddr;
            if (memRdData[14:11] == `MSEU_OP_SUBROUTINE_RETURN) begin
                memNext.rd = 1'b1;
                memNext.addr = rspReg;
                stateNext = mseu_pkg::S_OPER;
            end else if (memRdData[14:11] == `MSEU_OP_SHIFT_SKIP) begin
                stateNext = mseu_pkg::S_EXEC;
            end else if (memRdData[`MSEU_IND_BIT]) begin
                memNext.rd = 1'b1;
                memNext.addr = formedAddr;
                stateNext = mseu_pkg::S_IND_REQ;
            end else if (needsOperand) begin
                memNext.rd = 1'b1;
                memNext.addr = formedAddr;
                stateNext = mseu_pkg::S_OPER;
            end else begin
                stateNext = mseu_pkg::S_EXEC;
            end
        end
        mseu_pkg::S_IND_REQ: begin
            stateNext = mseu_pkg::S_IND_DATA;
        end
        mseu_pkg::S_IND_DATA: begin
            // single level: the fetched word is the final address
            eaNext = memRdData[14:0];
            if (irReg[14:11] <= `MSEU_OP_ADD_TO_SECOND_ACC || irReg[14:11] == `MSEU_OP_INCREMENT_SKIP_ZERO
                || irReg[14:11] == `MSEU_OP_DECREMENT_SKIP_ZERO || irReg[14:11] == `MSEU_OP_LOGIC_AND
                || irReg[14:11] == `MSEU_OP_INCLUSIVE_OR_OP) begin
                memNext.rd = 1'b1;
                memNext.addr = memRdData[14:0];
                stateNext = mseu_pkg::S_OPER;
            end else begin
                stateNext = mseu_pkg::S_EXEC;
            end
        end
        mseu_pkg::S_OPER: begin
            stateNext = mseu_pkg::S_EXEC;
        end
        mseu_pkg::S_EXEC: begin
            stateNext = mseu_pkg::S_IDLE;
            pcNext = pcReg + 15'h0001;
            unique case (irReg[14:11])
                `MSEU_OP_LOAD_FIRST_ACC: accANext = operand;
                `MSEU_OP_LOAD_SECOND_ACC: accBNext = operand;
                `MSEU_OP_COMPARE_FIRST_ACC, `MSEU_OP_COMPARE_SECOND_ACC: begin
                    if (curAcc != operand) begin
                        pcNext = pcReg + 15'h0002;
                    end
                end
                `MSEU_OP_ADD_TO_FIRST_ACC, `MSEU_OP_ADD_TO_SECOND_ACC: begin
                    if (irReg[`MSEU_SECOND_BIT]) begin
                        accBNext = sum17[15:0];
                    end else begin
                        accANext = sum17[15:0];
                    end
                    if (sum17[16]) begin
                        flagsNext.carry = 1'b1;
                    end
                    // carries out of 14 and 15 differ
                    if (sum17[16] ^ low16[15]) begin
                        flagsNext.signedWrapFlag = 1'b1;
                    end
                end
                `MSEU_OP_STORE_FIRST_ACC, `MSEU_OP_STORE_SECOND_ACC: begin
                    memNext.wr = 1'b1;
                    memNext.addr = eaReg;
                    memNext.data = curAcc;
                end
                `MSEU_OP_CALL_SUBROUTINE: begin
                    rspNext = rspReg + 15'h0001;
                    memNext.wr = 1'b1;
                    memNext.addr = rspReg + 15'h0001;
                    memNext.data = {1'b0, pcReg};
                    pcNext = eaReg;
                end
                `MSEU_OP_BRANCH_ALWAYS: pcNext = eaReg;
                // write back, skip on zero, flags untouched
                `MSEU_OP_INCREMENT_SKIP_ZERO, `MSEU_OP_DECREMENT_SKIP_ZERO: begin
                    memNext.wr = 1'b1;
                    memNext.addr = eaReg;
                    memNext.data = irReg[11] ? operand - 16'h0001 : operand + 16'h0001;
                    if (memNext.data == 16'h0000) begin
                        pcNext = pcReg + 15'h0002;
                    end
                end
                `MSEU_OP_LOGIC_AND: accANext = accAReg & operand;
                `MSEU_OP_INCLUSIVE_OR_OP: accANext = accAReg | operand;
                `MSEU_OP_SUBROUTINE_RETURN: begin
                    pcNext = operand[14:0] + disp15;
                    rspNext = rspReg - 15'h0001;
                    popReq = irReg[`MSEU_POP_BIT];
                end
                `MSEU_OP_SHIFT_SKIP: begin
                    if (irReg[`MSEU_GROUP_BIT]) begin
                        if (skipCond) begin
                            pcNext = pcReg + disp15;
                        end
                    end else if (irReg[`MSEU_SHIFT_ACC_BIT]) begin
                        accBNext = result;
                    end else begin
                        accANext = result;
                    end
                end
            endcase
        end
        default: begin
            stateNext = mseu_pkg::S_IDLE;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
        stateReg <= mseu_pkg::S_IDLE;
        irReg <= `MSEU_RST_WORD;
        eaReg <= `MSEU_RST_ADDR;
    end else begin
        stateReg <= stateNext;
        irReg <= irNext;
        eaReg <= eaNext;
    end
end

always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
        pcReg <= `MSEU_RST_ADDR;
        rspReg <= `MSEU_RST_ADDR;
        accAReg <= `MSEU_RST_WORD;
        accBReg <= `MSEU_RST_WORD;
        flagsReg <= 2'h0;
    end else begin
        pcReg <= pcNext;
        rspReg <= rspNext;
        accAReg <= accANext;
        accBReg <= accBNext;
        flagsReg <= flagsNext;
    end
end

always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
        memReg <= '0;
    end else begin
        memReg <= memNext;
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt pins are asynchronous: two stages before anything looks at them
always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
        syncA <= 6'h00;
        syncB <= 6'h00;
    end else begin
        syncA <= {intReqPin, intHighPin, intCodePin};
        syncB <= syncA;
    end
end

// grant only above level in service
always_comb begin
    reqLevel = syncB[4] ? `MSEU_LEVEL_HIGH : `MSEU_LEVEL_LOW;
    // a pop in the same cycle goes first; the request is seen again next cycle
    grantNow = syncB[5] && (reqLevel > levelReg) && !popReq;
end

always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
        levelReg <= `MSEU_RST_LEVEL;
        intGrant <= 1'b0;
    end else begin
        intGrant <= grantNow;
        if (popReq) begin
            if (levelReg != `MSEU_RST_LEVEL) begin
                levelReg <= levelReg - 2'h1;
            end
        end else if (grantNow) begin
            levelReg <= reqLevel;
        end
    end
end

// select code stack, entry 0 is top
for (genvar i = 0; i < `MSEU_STACK_DEPTH; i++) begin : gStack
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stackReg[i] <= `MSEU_RST_CODE;
        end else if (popReq) begin
            stackReg[i] <= (i == `MSEU_STACK_DEPTH - 1) ? `MSEU_RST_CODE : stackReg[(i + 1) % `MSEU_STACK_DEPTH];
        end else if (grantNow) begin
            stackReg[i] <= (i == 0) ? syncB[3:0] : stackReg[(i + `MSEU_STACK_DEPTH - 1) % `MSEU_STACK_DEPTH];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// register port: run bit plus read-back, data valid only the cycle after a read
always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
        runReg <= 1'b0;
    end else if (regWr && regAddr == `MSEU_REG_CTRL) begin
        runReg <= regWrData[0];
    end
end

always_comb begin
    unique case (regAddr)
        `MSEU_REG_CTRL: rdMux = {15'h0000, runReg};
        `MSEU_REG_STATUS: rdMux = {9'h000, stackReg[0], levelReg, stateReg == mseu_pkg::S_IDLE};
        `MSEU_REG_ACC_FIRST: rdMux = accAReg;
        `MSEU_REG_ACC_SECOND: rdMux = accBReg;
        `MSEU_REG_PROG_CNT: rdMux = {1'b0, pcReg};
        `MSEU_REG_RET_PTR: rdMux = {1'b0, rspReg};
        `MSEU_REG_FLAGS: rdMux = {14'h0000, flagsReg};
        default: rdMux = 16'h0000;
    endcase
end

always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
        regRdData <= 16'h0000;
    end else begin
        regRdData <= regRd ? rdMux : 16'h0000;
    end
end

endmodule : mseu_core

// file: verif/mseu_core_asserts.sv
`timescale 1ns/1ps
module mseu_core_asserts (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regRdData,
    input wire mseu_pkg::mseu_mem_req_t memReq,
    input wire logic [15:0] memRdData,
    input wire logic intReqPin,
    input wire logic intHighPin,
    input wire logic [3:0] intCodePin,
    input wire logic intGrant,
    input wire logic [3:0] selCode
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////
    a_rdata_quiet: assert property (!$past(regRd) |-> regRdData == 16'h0000)
        else $error("read data not zero outside the answer cycle");
    a_status_top: assert property ($past(regRd) && $past(regAddr) == 4'h1 |-> regRdData[6:3] == $past(selCode))
        else $error("status does not show the select code on top");
    a_mem_excl: assert property (!(memReq.rd && memReq.wr))
        else $error("memory read and write together");
    a_rd_pulse: assert property (memReq.rd |=> !memReq.rd)
        else $error("memory read longer than one cycle");
    a_wr_pulse: assert property (memReq.wr |=> !memReq.wr)
        else $error("memory write longer than one cycle");
    a_req_hold: assert property (!memReq.rd && !memReq.wr |-> $stable(memReq.addr) && $stable(memReq.data))
        else $error("memory address or data moved between requests");
    a_grant_pulse: assert property (intGrant |=> !intGrant)
        else $error("grant longer than one cycle");
    a_grant_cause: assert property (intGrant |-> $past(intReqPin, 3))
        else $error("grant without a request");
    a_grant_code: assert property (intGrant |-> selCode == $past(intCodePin, 3))
        else $error("granted code not pushed on top");

    c_grant: cover property (intGrant);
    c_write: cover property (memReq.wr);
    c_reads: cover property (memReq.rd ##2 memReq.rd);
endmodule : mseu_core_asserts

bind mseu_core mseu_core_asserts u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .memReq(memReq),
    .memRdData(memRdData), .intReqPin(intReqPin), .intHighPin(intHighPin), .intCodePin(intCodePin),
    .intGrant(intGrant), .selCode(selCode));

// file: verif/mseu_mem_model.sv
`timescale 1ns/1ps
module mseu_mem_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire mseu_pkg::mseu_mem_req_t memReq,
    output logic [15:0] memRdData
);
    logic [15:0] mem [0:32767];

    // no wait states: data one cycle after the read, garbage otherwise
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            memRdData <= 16'h0000;
        end else if (memReq.rd) begin
            memRdData <= mem[memReq.addr];
        end else begin
            memRdData <= ~memRdData;
        end
        if (!sys_rst && memReq.wr) begin
            mem[memReq.addr] <= memReq.data;
        end
    end
endmodule : mseu_mem_model

// file: verif/mseu_core_bench.sv
`timescale 1ns/1ps
`include "mseu_defs.svh"
module mseu_core_bench;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdData;
    mseu_pkg::mseu_mem_req_t memReq;
    logic [15:0] memRdData;
    logic intReqPin = 1'b0;
    logic intHighPin = 1'b0;
    logic [3:0] intCodePin = 4'h0;
    logic intGrant;
    logic [3:0] selCode;
    int n_fail = 0;
    int compares = 0;
    logic [15:0] rd;

    always #2.5 clk_sys = ~clk_sys;

    mseu_core DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .memReq(memReq), .memRdData(memRdData),
        .intReqPin(intReqPin), .intHighPin(intHighPin), .intCodePin(intCodePin), .intGrant(intGrant),
        .selCode(selCode));
    mseu_mem_model MEM (.clk_sys(clk_sys), .sys_rst(sys_rst), .memReq(memReq), .memRdData(memRdData));

    ////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    task check(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask : rd_reg

    task expect_reg(input logic [3:0] a, input logic [15:0] exp, input string what);
        rd_reg(a, rd);
        check(rd, exp, what);
    endtask : expect_reg

    // request held until well past the grant, then dropped
    task irq(input logic hi, input logic [3:0] code, input int expAt, input logic [15:0] expStatus);
        int at;
        at = 0;
        @(posedge clk_sys);
        intReqPin <= 1'b1;
        intHighPin <= hi;
        intCodePin <= code;
        for (int i = 1; i <= 6; i++) begin
            @(posedge clk_sys);
            #1;
            if (intGrant === 1'b1 && at == 0) at = i;
        end
        @(posedge clk_sys);
        intReqPin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check(16'(at), 16'(expAt), "grant cycle");
        check({12'h000, selCode}, {12'h000, expStatus[6:3]}, "select code output");
        expect_reg(`MSEU_REG_STATUS, expStatus, "status after request");
    endtask : irq

    function automatic logic [15:0] mr(input logic ind, input logic [3:0] op, input logic cur, input logic [9:0] off);
        return {ind, op, cur, off};
    endfunction : mr

    function automatic logic [15:0] sh(input mseu_pkg::mseu_shift_t k, input logic acc, input int n);
        return {1'b0, 4'hF, 1'b0, 3'b000, k, acc, 4'(n - 1)};
    endfunction : sh

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        report_and_stop;
    end

    initial begin
        MEM.mem[16'h0010] = 16'h7FFF;
        MEM.mem[16'h0011] = 16'h0001;
        MEM.mem[16'h0012] = 16'h8000;
        MEM.mem[16'h0013] = 16'h0430;
        MEM.mem[16'h0014] = 16'h8000;
        MEM.mem[16'h0015] = 16'hDEAD;
        MEM.mem[16'h0016] = 16'hFFFF;
        MEM.mem[16'h0017] = 16'h0005;
        MEM.mem[16'h0018] = 16'h80F0;
        MEM.mem[16'h0019] = 16'h000F;
        MEM.mem[16'h001A] = 16'h0412;
        MEM.mem[16'h0420] = 16'h8001;
        // operands only on base page or the program's own page
        MEM.mem[16'h0400] = mr(1'b0, `MSEU_OP_LOAD_FIRST_ACC, 1'b0, 10'h010);
        MEM.mem[16'h0401] = mr(1'b0, `MSEU_OP_ADD_TO_FIRST_ACC, 1'b0, 10'h011);
        MEM.mem[16'h0402] = mr(1'b0, `MSEU_OP_LOAD_SECOND_ACC, 1'b1, 10'h020);
        MEM.mem[16'h0403] = mr(1'b0, `MSEU_OP_ADD_TO_SECOND_ACC, 1'b0, 10'h012);
        MEM.mem[16'h0404] = mr(1'b1, `MSEU_OP_STORE_FIRST_ACC, 1'b0, 10'h013);
        MEM.mem[16'h0405] = mr(1'b0, `MSEU_OP_COMPARE_FIRST_ACC, 1'b0, 10'h014);
        MEM.mem[16'h0406] = mr(1'b0, `MSEU_OP_COMPARE_SECOND_ACC, 1'b0, 10'h014);
        MEM.mem[16'h0407] = mr(1'b0, `MSEU_OP_LOAD_FIRST_ACC, 1'b0, 10'h015);
        MEM.mem[16'h0408] = mr(1'b0, `MSEU_OP_INCREMENT_SKIP_ZERO, 1'b0, 10'h016);
        MEM.mem[16'h0409] = mr(1'b0, `MSEU_OP_LOAD_FIRST_ACC, 1'b0, 10'h015);
        MEM.mem[16'h040A] = mr(1'b0, `MSEU_OP_DECREMENT_SKIP_ZERO, 1'b0, 10'h017);
        MEM.mem[16'h040B] = mr(1'b0, `MSEU_OP_LOGIC_AND, 1'b0, 10'h018);
        MEM.mem[16'h040C] = mr(1'b0, `MSEU_OP_INCLUSIVE_OR_OP, 1'b0, 10'h019);
        MEM.mem[16'h040D] = mr(1'b0, `MSEU_OP_CALL_SUBROUTINE, 1'b1, 10'h040);
        MEM.mem[16'h0440] = sh(mseu_pkg::SH_ARITH_RIGHT, 1'b0, 4);
        MEM.mem[16'h0441] = sh(mseu_pkg::SH_ROTATE_RIGHT, 1'b1, 1);
        MEM.mem[16'h0442] = sh(mseu_pkg::SH_LOGIC_RIGHT, 1'b1, 3);
        MEM.mem[16'h0443] = sh(mseu_pkg::SH_LOGIC_LEFT, 1'b0, 1);
        MEM.mem[16'h0444] = {1'b0, 4'hE, 1'b0, 3'b000, 1'b1, 6'h01};
        MEM.mem[16'h040E] = {1'b0, 4'hF, 1'b1, 1'b0, 1'b1, 2'b00, 6'h05};
        MEM.mem[16'h040F] = mr(1'b1, `MSEU_OP_BRANCH_ALWAYS, 1'b0, 10'h01A);
        MEM.mem[16'h0410] = mr(1'b0, `MSEU_OP_BRANCH_ALWAYS, 1'b1, 10'h010);
        MEM.mem[16'h0411] = mr(1'b0, `MSEU_OP_LOAD_FIRST_ACC, 1'b0, 10'h015);
        MEM.mem[16'h0412] = {1'b0, 4'hF, 1'b1, 1'b1, 1'b0, 2'b00, 6'h3E};
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            expect_reg(4'(a), (a == 1) ? 16'h0001 : 16'h0000, "reset value");
        end
        $display("test reset values done");

        irq(1'b0, 4'h5, 3, 16'h002B);
        irq(1'b1, 4'h9, 3, 16'h004D);
        irq(1'b0, 4'h3, 0, 16'h004D);
        $display("test interrupt grant done");

        wr_reg(`MSEU_REG_PROG_CNT, 16'h0400);
        expect_reg(`MSEU_REG_PROG_CNT, 16'h0400, "program counter write");
        wr_reg(`MSEU_REG_CTRL, 16'h0001);
        repeat (400) @(posedge clk_sys);
        wr_reg(`MSEU_REG_CTRL, 16'h0000);
        for (int i = 0; i < 20; i++) begin
            rd_reg(`MSEU_REG_STATUS, rd);
            if (rd[0] === 1'b1) break;
        end
        expect_reg(`MSEU_REG_STATUS, 16'h002B, "status after pop");
        expect_reg(`MSEU_REG_ACC_FIRST, 16'hF000, "first accumulator");
        expect_reg(`MSEU_REG_ACC_SECOND, 16'h1000, "second accumulator");
        expect_reg(`MSEU_REG_PROG_CNT, 16'h0410, "program counter");
        expect_reg(`MSEU_REG_RET_PTR, 16'h0000, "return pointer");
        expect_reg(`MSEU_REG_FLAGS, 16'h0003, "carry and wrap flags");
        check(MEM.mem[16'h0430], 16'h8000, "stored word");
        check(MEM.mem[16'h0016], 16'h0000, "incremented word");
        check(MEM.mem[16'h0017], 16'h0004, "decremented word");
        check(MEM.mem[16'h0001], 16'h040D, "saved call location");
        $display("test program run done");
        report_and_stop;
    end
endmodule : mseu_core_bench
